// [lmd_consts.svh]
// constants for the multiplexed lcd drive block
`ifndef LMD_CONSTS_SVH
`define LMD_CONSTS_SVH

// register byte offsets
`define LMD_ADR_CTRL      8'h00
`define LMD_ADR_STATUS    8'h04
`define LMD_ADR_ROW_BASE  8'h10
`define LMD_ADR_ROW_LAST  8'h2c

// control field positions
`define LMD_CTRL_MODE_LSB 0
`define LMD_CTRL_HALF_BIT 2
`define LMD_CTRL_EN_BIT   3

// drive mode field encodings
`define LMD_MODE_STATIC   2'h1
`define LMD_MODE_MUX2     2'h2
`define LMD_MODE_MUX3     2'h3
`define LMD_MODE_MUX4     2'h0

// reset values
`define LMD_MODE_RST      2'h0
`define LMD_HALF_RST      1'h0
`define LMD_EN_RST        1'h0

// ladder level indices, vss upward to the panel supply level
`define LMD_LVL_VSS       2'h0
`define LMD_LVL_LO        2'h1
`define LMD_LVL_HI        2'h2
`define LMD_LVL_VLCD      2'h3

// timing: frame is 24 selected clock ticks, split into n slots
`define LMD_FRAME_TICKS   24
`define LMD_SLOT_STATIC   5'h18
`define LMD_SLOT_MUX2     5'h0c
`define LMD_SLOT_MUX3     5'h08
`define LMD_SLOT_MUX4     5'h06
`define LMD_COLS          40

// system clock and nominal internal oscillator rate
`define LMD_CLK_HZ        20000000
`define LMD_OSC_HZ        2000

`endif

// [lmd_drive.sv]
// backplane and segment multiplex drive with wishbone registers
//
// Functional notes
// - static mode: one backplane, each segment carries one bit per column.
// - two-way mode time-shares two backplanes, half or third bias selectable.
// - three-way mode sequences three backplanes with matching row data.
// - four-way mode sequences four backplanes with matching row data.
// - addressable elements equal active backplanes times forty, at most 160.
// - holding register keeps displayed bits stable while drive is generated.
// - level selection follows drive mode and bias loaded by configuration write.
// - half bias in two-way mode closes the centre divider bypass switch.
// - half bias also accepted in three-way and four-way modes.
// - bias is one over one plus a; a is 1 half, 2 third.
// - multiplex factor n is 1, 2, 3, 4 for the four modes.
// - strap low: internal oscillator runs the block and drives clock pin.
// - strap high: clock pin is an input and times all drive.
// - frame rate comes only from the selected clock.
// - mode field: 01 static, 10 two-way, 11 three-way, 00 four-way default.
// - frame frequency is the selected clock divided by twenty-four.
// - backplanes mirror: three-way 3 copies 1, two-way 0/2 1/3, static all.
// - disabled display holds all backplane and segment outputs at the panel supply level.
`timescale 1ns/10ps
`default_nettype none
`include "lmd_consts.svh"

module lmd_drive
  import lmd_pkg::*;
#(
  parameter int OSC_DIV = `LMD_CLK_HZ / `LMD_OSC_HZ
)
(
  // system
  input  wire logic              CLK,
  input  wire logic              RST,
  // wishbone slave
  input  wire logic              WB_CYC_I,
  input  wire logic              WB_STB_I,
  input  wire logic              WB_WE_I,
  input  wire logic [7:0]        WB_ADR_I,
  input  wire logic [3:0]        WB_SEL_I,
  input  wire logic [31:0]       WB_DAT_I,
  output var  logic [31:0]       WB_DAT_O,
  output var  logic              WB_ACK_O,
  // clock source strap and clock pin
  input  wire logic              CLOCK_SOURCE_STRAP,
  input  wire logic              CLK_PIN_I,
  output var  logic              CLK_PIN_O,
  output var  logic              CLK_PIN_OE,
  // panel drive, ladder indices
  output var  lmd_level_t        BACKPLANE_OUT_0,
  output var  lmd_level_t        BACKPLANE_OUT_1,
  output var  lmd_level_t        BACKPLANE_OUT_2,
  output var  lmd_level_t        BACKPLANE_OUT_3,
  output var  lmd_level_t [39:0] SEGMENT_OUTPUTS,
  output var  logic              BIAS_BYPASS
);

  // reset value of the whole state, every field named so none is left implicit
  // drive outputs start at the panel supply level so a fresh panel sees no dc
  localparam lmd_state_s ST_RST = '{
    mode:       `LMD_MODE_RST,
    half_bias:  `LMD_HALF_RST,
    enable:     `LMD_EN_RST,
    ram:        '0,
    hold:       '0,
    osc_cnt:    16'h0,
    clk_out:    1'h0,
    clk_oe:     1'h0,
    ext_s1:     1'h0,
    ext_s2:     1'h0,
    ext_prev:   1'h0,
    strap_s1:   1'h0,
    strap_s2:   1'h0,
    strap_wait: 2'h0,
    ext_src:    1'h0,
    tick_cnt:   5'h0,
    slot:       2'h0,
    pol:        1'h0,
    bp:         {4{`LMD_LVL_VLCD}},
    seg:        {`LMD_COLS{`LMD_LVL_VLCD}},
    bypass:     1'h0,
    ack:        1'h0,
    dat:        32'h0
  };

  lmd_state_s r;
  lmd_state_s n;

  // multiplex factor of a mode
  function automatic logic [2:0] mux_of(input logic [1:0] m);
    case (m)
      `LMD_MODE_STATIC: return 3'h1;
      `LMD_MODE_MUX2:   return 3'h2;
      `LMD_MODE_MUX3:   return 3'h3;
      default:          return 3'h4;
    endcase
  endfunction

  // ticks per backplane slot, so that n slots fill one frame
  function automatic logic [4:0] slot_len_of(input logic [1:0] m);
    case (m)
      `LMD_MODE_STATIC: return `LMD_SLOT_STATIC;
      `LMD_MODE_MUX2:   return `LMD_SLOT_MUX2;
      `LMD_MODE_MUX3:   return `LMD_SLOT_MUX3;
      default:          return `LMD_SLOT_MUX4;
    endcase
  endfunction

  // logical row driven by physical backplane k
  function automatic logic [1:0] row_of(input logic [1:0] k, input logic [1:0] m);
    case (m)
      `LMD_MODE_STATIC: return 2'h0;
      `LMD_MODE_MUX2:   return {1'b0, k[0]};
      `LMD_MODE_MUX3:   return (k == 2'h3) ? 2'h1 : k;
      default:          return k;
    endcase
  endfunction

  // backplane level: selected swings full scale, others sit on inner taps
  function automatic lmd_level_t bp_level(input logic sel, input logic pol, input logic half);
    if (sel)
      return pol ? `LMD_LVL_VLCD : `LMD_LVL_VSS;
    else if (half)
      return `LMD_LVL_LO;
    else
      return pol ? `LMD_LVL_LO : `LMD_LVL_HI;
  endfunction

  // segment level: on opposes the selected backplane, off stays near it
  function automatic lmd_level_t seg_level(input logic on, input logic pol, input logic two_lvl);
    if (on)
      return pol ? `LMD_LVL_VSS : `LMD_LVL_VLCD;
    else if (two_lvl)
      return pol ? `LMD_LVL_VLCD : `LMD_LVL_VSS;
    else
      return pol ? `LMD_LVL_HI : `LMD_LVL_LO;
  endfunction

  // level encoding used on every drive output:
  //   0 is vss, 1 the lower tap, 2 the upper tap, 3 the panel supply level.
  // a selected backplane swings between the rails; unselected backplanes
  // sit on an inner tap, so an off element never sees more than one third
  // of the supply in third bias. in half bias both inner taps merge into
  // one, reported as the lower tap, which is why the bypass switch closes.
  // segments take the rail opposite a selected backplane when on, and the
  // tap next to it when off, or its own rail in half bias and static. polarity flips every frame so that the sum of
  // voltage across each element over two frames is zero; a stuck polarity
  // would leave dc across the liquid and damage it over time.
  // the sequencer keeps running while the display is disabled, so that
  // enabling mid-frame picks up the right slot and polarity at once.
  //
  // next state
  always_comb
  begin
    logic       int_tick;
    logic       tick;
    logic [2:0] nmux;
    logic [4:0] slen;
    logic       stat;
    logic [1:0] bias_a;
    logic [2:0] levels;
    logic [7:0] elems;
    logic [1:0] ri;
    logic [7:0] roff;
    logic [31:0] rd;
    logic       req;
    n        = r;
    int_tick = 1'b0;
    tick     = 1'b0;
    nmux     = mux_of(r.mode);
    slen     = slot_len_of(r.mode);
    stat     = (r.mode == `LMD_MODE_STATIC);
    bias_a   = r.half_bias ? 2'h1 : 2'h2;
    levels   = stat ? 3'h2 : (r.half_bias ? 3'h3 : 3'h4);
    elems    = 8'(nmux) * 8'(`LMD_COLS);
    ri       = 2'h0;
    roff     = 8'h00;
    rd       = 32'h0;
    req      = WB_CYC_I & WB_STB_I & ~r.ack;

    // pin synchronisers and edge memory
    n.strap_s1 = CLOCK_SOURCE_STRAP;
    n.strap_s2 = r.strap_s1;
    n.ext_s1   = CLK_PIN_I;
    n.ext_s2   = r.ext_s1;
    n.ext_prev = r.ext_s2;

    // strap caught once, after the synchroniser has filled past reset;
    // taking it later would let a noisy strap swap the clock source under
    // a running frame, so a change only counts after the next reset
    if (r.strap_wait != 2'h3)
    begin
      n.strap_wait = r.strap_wait + 2'h1;
      if (r.strap_wait == 2'h2)
        n.ext_src = r.strap_s2;
    end

    // internal oscillator model: divider from the system clock
    int_tick = (r.osc_cnt == 16'(OSC_DIV - 1));
    n.osc_cnt = int_tick ? 16'h0 : r.osc_cnt + 16'h1;
    if (int_tick)
      n.clk_out = ~r.clk_out;

    // selected timing tick; pin drives out only on internal source
    tick = r.ext_src ? (r.ext_s2 & ~r.ext_prev) : int_tick;
    n.clk_oe = ~r.ext_src;

    // slot and frame sequencing, n slots of 24/n ticks; the compares use
    // greater-or-equal so that a mode change mid-frame that leaves a counter
    // above its new limit wraps at the next tick instead of running away;
    // the hold copy at frame end keeps row data steady for a whole frame
    if (tick)
    begin
      if (r.tick_cnt >= slen - 5'h1)
      begin
        n.tick_cnt = 5'h0;
        if ({1'b0, r.slot} >= nmux - 3'h1)
        begin
          n.slot = 2'h0;
          n.pol  = ~r.pol;
          n.hold = r.ram;
        end
        else
          n.slot = r.slot + 2'h1;
      end
      else
        n.tick_cnt = r.tick_cnt + 5'h1;
    end

    // backplane drive per physical output
    for (int k = 0; k < 4; k++)
    begin
      if (!r.enable)
        n.bp[k] = `LMD_LVL_VLCD;
      else
        n.bp[k] = bp_level(row_of(2'(k), r.mode) == r.slot,
                           r.pol, r.half_bias | stat);
    end

    // segment drive from the held row of the current slot
    for (int c = 0; c < `LMD_COLS; c++)
    begin
      if (!r.enable)
        n.seg[c] = `LMD_LVL_VLCD;
      else
        n.seg[c] = seg_level(r.hold[r.slot][c], r.pol,
                             r.half_bias | stat);
    end

    // centre divider bypass for half bias in any multiplex mode
    n.bypass = r.half_bias & ~stat;

    // wishbone map:
    //   ctrl   : mode in bits 1:0, half bias in bit 2, enable in bit 3
    //   status : slot, polarity, source, n, a, levels, bypass, elements
    //   rows   : row r low word at base plus 8r, high byte one word above
    // a request is taken only while ack is low, so a master that keeps
    // strobe high over the ack cycle is not answered twice.
    // unmapped addresses are acknowledged and read as zero so that a stray
    // access never hangs the bus; writes to them are dropped.
    // read data is zero outside the ack cycle to keep the bus quiet.
    // wishbone: one registered ack per request
    n.ack = req;
    n.dat = 32'h0;
    if (req)
    begin
      if (WB_ADR_I == `LMD_ADR_CTRL)
      begin
        rd = {28'h0, r.enable, r.half_bias, r.mode};
        if (WB_WE_I && WB_SEL_I[0])
        begin
          n.mode      = WB_DAT_I[`LMD_CTRL_MODE_LSB +: 2];
          n.half_bias = WB_DAT_I[`LMD_CTRL_HALF_BIT];
          n.enable    = WB_DAT_I[`LMD_CTRL_EN_BIT];
        end
      end
      else if (WB_ADR_I == `LMD_ADR_STATUS)
      begin
        rd = {7'h0, r.enable, elems,
              3'h0, r.bypass, levels, bias_a, nmux,
              r.ext_src, r.pol, r.slot};
      end
      else if (WB_ADR_I >= `LMD_ADR_ROW_BASE && WB_ADR_I <= `LMD_ADR_ROW_LAST
               && WB_ADR_I[1:0] == 2'h0)
      begin
        roff = WB_ADR_I - `LMD_ADR_ROW_BASE;
        ri   = roff[4:3];
        if (!roff[2])
        begin
          rd = r.ram[ri][31:0];
          for (int b = 0; b < 4; b++)
          begin
            if (WB_WE_I && WB_SEL_I[b])
              n.ram[ri][8*b +: 8] = WB_DAT_I[8*b +: 8];
          end
        end
        else
        begin
          rd = {24'h0, r.ram[ri][39:32]};
          if (WB_WE_I && WB_SEL_I[0])
            n.ram[ri][39:32] = WB_DAT_I[7:0];
        end
      end
      else
        rd = 32'h0;
      if (!WB_WE_I)
        n.dat = rd;
    end
  end

  // state register
  always_ff @(posedge CLK)
  begin
    if (RST)
      r <= ST_RST;
    else
      r <= n;
  end

  // outputs straight from the state register
  assign WB_DAT_O        = r.dat;
  assign WB_ACK_O        = r.ack;
  assign CLK_PIN_O       = r.clk_out;
  assign CLK_PIN_OE      = r.clk_oe;
  assign BACKPLANE_OUT_0 = r.bp[0];
  assign BACKPLANE_OUT_1 = r.bp[1];
  assign BACKPLANE_OUT_2 = r.bp[2];
  assign BACKPLANE_OUT_3 = r.bp[3];
  assign SEGMENT_OUTPUTS = r.seg;
  assign BIAS_BYPASS     = r.bypass;

endmodule

`default_nettype wire

// [lmd_drive_bench.sv]
// self-checking bench for the lcd drive block
`timescale 1ns/10ps
`default_nettype none
module lmd_drive_bench
  import lmd_pkg::*;
;
  logic              clk, rst, cyc, stb, we, strap, pin_i, ack, pin_o, pin_oe, bypass, ext_run;
  logic [7:0]        adr;
  logic [3:0]        sel;
  logic [31:0]       dat_i, dat_o, q;
  lmd_level_t        bp [4];
  lmd_level_t [39:0] seg;
  logic signed [2:0] elem_v;
  logic [11:0]       r;
  logic [7:0]        hold;
  int                err_total, comparisons, chg;
  // rows: control value, then n and a
  logic [11:0]       rows [7] = '{12'h910, 12'ha22, 12'he21, 12'hf31, 12'hb32, 12'hc41, 12'h842};
  lmd_drive #(.OSC_DIV(4)) dut (.CLK(clk), .RST(rst), .WB_CYC_I(cyc), .WB_STB_I(stb), .WB_WE_I(we),
    .WB_ADR_I(adr), .WB_SEL_I(sel), .WB_DAT_I(dat_i), .WB_DAT_O(dat_o), .WB_ACK_O(ack),
    .CLOCK_SOURCE_STRAP(strap), .CLK_PIN_I(pin_i), .CLK_PIN_O(pin_o), .CLK_PIN_OE(pin_oe),
    .BACKPLANE_OUT_0(bp[0]), .BACKPLANE_OUT_1(bp[1]), .BACKPLANE_OUT_2(bp[2]), .BACKPLANE_OUT_3(bp[3]),
    .SEGMENT_OUTPUTS(seg), .BIAS_BYPASS(bypass));
  lmd_panel u_panel (.BP_ROW(bp[0]), .SEG_COL(seg[0]), .ELEM_V(elem_v));
  // free running clock, never stopped
  initial
  begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end
  // external clock pin source
  always
  begin
    repeat (5) @(posedge clk);
    if (ext_run)
      pin_i <= ~pin_i;
  end
  // one classic wishbone cycle
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] o);
    int t;
    t = 0;
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    dat_i <= d;
    do @(posedge clk); while (ack !== 1'b1 && ++t < 20);
    o = dat_o;
    cyc <= 1'b0;
    stb <= 1'b0;
    @(posedge clk);
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp)
    begin
      err_total++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic sel_wait(input int k);
    int t;
    t = 0;
    while (bp[k] != 2'h0 && bp[k] != 2'h3 && t < 300)
    begin
      @(posedge clk);
      t++;
    end
  endtask
  // expected status from control, n and a
  function automatic logic [31:0] sts(input logic [11:0] x);
    logic [7:0] n;
    logic [2:0] a;
    n = {4'h0, x[7:4]};
    a = x[2:0];
    return {7'h0, x[11], n * 8'h28, 3'h0, x[10] && n != 8'h1, (a == 3'h0) ? 3'h2 : a + 3'h2, a[1:0], n[2:0], 4'h0};
  endfunction
  task automatic complete_run;
    $display("comparisons=%0d err_total=%0d", comparisons, err_total);
    if (err_total == 0 && comparisons > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  // main sequence
  initial
  begin
    {rst, cyc, stb, we, strap, pin_i, ext_run, adr, sel, dat_i} = {1'b1, 14'h0, 4'hf, 32'h0};
    repeat (5) @(posedge clk);
    rst <= 1'b0;
    repeat (2) @(posedge clk);
    chk({24'h0, bp[0], bp[1], bp[2], bp[3]}, 32'hff);
    chk({31'h0, seg === {40{2'h3}}}, 32'h1);
    chk({31'h0, pin_oe}, 32'h1);
    wb(1'b0, 8'h00, 32'h0, q);
    chk(q & 32'hf, 32'h0);
    wb(1'b1, 8'h80, 32'hffffffff, q);
    wb(1'b0, 8'h80, 32'h0, q);
    chk(q, 32'h0);
    for (int i = 0; i < 7; i++)
    begin
      r = rows[i];
      wb(1'b1, 8'h00, {28'h0, r[11:8]}, q);
      wb(1'b0, 8'h00, 32'h0, q);
      chk(q & 32'hf, {28'h0, r[11:8]});
      repeat (320) @(posedge clk);
      wb(1'b0, 8'h04, 32'h0, q);
      chk(q & ((r[3:0] == 4'h0) ? 32'h01ff1e78 : 32'h01ff1ff8), sts(r));
      chk({31'h0, {1'b0, q[1:0]} < r[6:4]}, 32'h1);
    end
    wb(1'b1, 8'h10, 32'h1, q);
    repeat (200) @(posedge clk);
    sel_wait(0);
    chk({29'h0, elem_v}, bp[0] == 2'h3 ? 32'h3 : 32'h5);
    sel_wait(1);
    chk({30'h0, seg[0]}, bp[1] == 2'h3 ? 32'h2 : 32'h1);
    strap <= 1'b1;
    rst <= 1'b1;
    repeat (5) @(posedge clk);
    rst <= 1'b0;
    repeat (8) @(posedge clk);
    chk({31'h0, pin_oe}, 32'h0);
    wb(1'b1, 8'h00, 32'h8, q);
    hold = {bp[0], bp[1], bp[2], bp[3]};
    repeat (200) @(posedge clk);
    chk({24'h0, bp[0], bp[1], bp[2], bp[3]}, {24'h0, hold});
    ext_run <= 1'b1;
    chg = 0;
    repeat (800)
    begin
      @(posedge clk);
      if (bp[0] != hold[7:6])
        chg++;
    end
    chk({31'h0, chg != 0}, 32'h1);
    wb(1'b0, 8'h04, 32'h0, q);
    chk({31'h0, q[3]}, 32'h1);
    wb(1'b1, 8'h00, 32'h0, q);
    repeat (310) @(posedge clk);
    chk({24'h0, bp[0], bp[1], bp[2], bp[3]}, 32'hff);
    chk({31'h0, seg === {40{2'h3}}}, 32'h1);
    complete_run;
  end
  // watchdog against a hang
  initial
  begin
    #(20000 * 50);
    err_total++;
    complete_run;
  end
endmodule
bind lmd_drive lmd_drive_props #(.OSC_DIV(OSC_DIV)) u_props (.CLK(CLK), .RST(RST), .WB_CYC_I(WB_CYC_I),
  .WB_STB_I(WB_STB_I), .WB_WE_I(WB_WE_I), .WB_ADR_I(WB_ADR_I), .WB_SEL_I(WB_SEL_I), .WB_DAT_I(WB_DAT_I),
  .WB_DAT_O(WB_DAT_O), .WB_ACK_O(WB_ACK_O), .CLK_PIN_O(CLK_PIN_O), .CLK_PIN_OE(CLK_PIN_OE),
  .BACKPLANE_OUT_0(BACKPLANE_OUT_0), .BACKPLANE_OUT_1(BACKPLANE_OUT_1), .BACKPLANE_OUT_2(BACKPLANE_OUT_2),
  .BACKPLANE_OUT_3(BACKPLANE_OUT_3), .SEGMENT_OUTPUTS(SEGMENT_OUTPUTS), .BIAS_BYPASS(BIAS_BYPASS));
`default_nettype wire

// [lmd_drive_props.sv]
// port assertions for the lcd drive block
`timescale 1ns/10ps
`default_nettype none
module lmd_drive_props
  import lmd_pkg::*;
#(
  parameter int OSC_DIV = 10000
)
(
  // system and bus
  input wire logic              CLK,
  input wire logic              RST,
  input wire logic              WB_CYC_I,
  input wire logic              WB_STB_I,
  input wire logic              WB_WE_I,
  input wire logic [7:0]        WB_ADR_I,
  input wire logic [3:0]        WB_SEL_I,
  input wire logic [31:0]       WB_DAT_I,
  input wire logic [31:0]       WB_DAT_O,
  input wire logic              WB_ACK_O,
  // clock pin and drive
  input wire logic              CLK_PIN_O,
  input wire logic              CLK_PIN_OE,
  input wire lmd_level_t        BACKPLANE_OUT_0,
  input wire lmd_level_t        BACKPLANE_OUT_1,
  input wire lmd_level_t        BACKPLANE_OUT_2,
  input wire lmd_level_t        BACKPLANE_OUT_3,
  input wire lmd_level_t [39:0] SEGMENT_OUTPUTS,
  input wire logic              BIAS_BYPASS
);
  localparam int FRAME = 24 * OSC_DIV;
  logic [1:0] mode_r;
  logic       half_r;
  logic       en_r;
  logic       pin_r;
  int         calm_r;
  int         osc_r;
  logic       calm;
  // control mirror and quiet time since the last write
  always_ff @(posedge CLK)
  begin
    if (RST)
    begin
      mode_r <= 2'h0;
      half_r <= 1'h0;
      en_r   <= 1'h0;
      calm_r <= 0;
    end
    else if (WB_CYC_I && WB_STB_I && WB_WE_I && WB_ACK_O)
    begin
      calm_r <= 0;
      if (WB_ADR_I == 8'h00 && WB_SEL_I[0])
        {en_r, half_r, mode_r} <= WB_DAT_I[3:0];
    end
    else if (calm_r < 3 * FRAME)
      calm_r <= calm_r + 1;
  end
  // cycles since the clock pin last changed
  always_ff @(posedge CLK)
  begin
    pin_r <= CLK_PIN_O;
    osc_r <= (RST || CLK_PIN_O != pin_r) ? 0 : osc_r + 1;
  end
  assign calm = calm_r >= 3 * FRAME;
  default clocking cb @(posedge CLK); endclocking
  default disable iff (RST);
  a_ack_next: assert property (WB_CYC_I && WB_STB_I && !WB_ACK_O |=> WB_ACK_O) else $error("ack late");
  a_ack_pulse: assert property (WB_ACK_O |=> !WB_ACK_O) else $error("ack too long");
  a_dat_quiet: assert property (!WB_ACK_O |-> WB_DAT_O == 32'h0) else $error("read data leaks");
  a_static_same: assert property (calm && mode_r == 2'h1 |-> BACKPLANE_OUT_0 == BACKPLANE_OUT_1 &&
    BACKPLANE_OUT_1 == BACKPLANE_OUT_2 && BACKPLANE_OUT_2 == BACKPLANE_OUT_3) else $error("static mirror");
  a_two_pairs: assert property (calm && mode_r == 2'h2 |-> BACKPLANE_OUT_0 == BACKPLANE_OUT_2 &&
    BACKPLANE_OUT_1 == BACKPLANE_OUT_3) else $error("two-way pairing");
  a_three_copy: assert property (calm && mode_r == 2'h3 |-> BACKPLANE_OUT_3 == BACKPLANE_OUT_1)
    else $error("three-way copy");
  a_dark_supply: assert property (calm && !en_r |-> BACKPLANE_OUT_0 == 2'h3 && BACKPLANE_OUT_3 == 2'h3 &&
    SEGMENT_OUTPUTS == {40{2'h3}}) else $error("dark level");
  a_bypass_half: assert property (calm |-> BIAS_BYPASS == (half_r && mode_r != 2'h1))
    else $error("bypass switch");
  a_frame_flip: assert property (calm && en_r && !half_r && CLK_PIN_OE |->
    (BACKPLANE_OUT_0 ^ $past(BACKPLANE_OUT_0, FRAME)) == 2'h3 &&
    (SEGMENT_OUTPUTS[0] ^ $past(SEGMENT_OUTPUTS[0], FRAME)) == 2'h3) else $error("frame polarity");
  a_clk_runs: assert property (CLK_PIN_OE |-> osc_r <= OSC_DIV + 2) else $error("clock out stuck");
  c_three_on: cover property (calm && en_r && mode_r == 2'h3);
  c_bypass: cover property (BIAS_BYPASS);
  c_read: cover property (WB_ACK_O && !WB_WE_I);
endmodule
`default_nettype wire

// [lmd_panel.sv]
// passive panel element at row 0 column 0
`timescale 1ns/10ps
`default_nettype none
module lmd_panel
  import lmd_pkg::*;
(
  // drive levels seen by the element
  input  wire lmd_level_t        BP_ROW,
  input  wire lmd_level_t        SEG_COL,
  output var  logic signed [2:0] ELEM_V
);
  // element sees backplane minus segment level
  assign ELEM_V = $signed({1'b0, BP_ROW}) - $signed({1'b0, SEG_COL});
endmodule
`default_nettype wire

// [lmd_pkg.sv]
// types shared by the multiplexed lcd drive block
package lmd_pkg;

  // index into the bias ladder
  typedef logic [1:0] lmd_level_t;

  // whole state of the drive block
  typedef struct packed {
    logic [1:0]             mode;
    logic                   half_bias;
    logic                   enable;
    logic [3:0][39:0]       ram;
    logic [3:0][39:0]       hold;
    logic [15:0]            osc_cnt;
    logic                   clk_out;
    logic                   clk_oe;
    logic                   ext_s1;
    logic                   ext_s2;
    logic                   ext_prev;
    logic                   strap_s1;
    logic                   strap_s2;
    logic [1:0]             strap_wait;
    logic                   ext_src;
    logic [4:0]             tick_cnt;
    logic [1:0]             slot;
    logic                   pol;
    lmd_level_t [3:0]       bp;
    lmd_level_t [39:0]      seg;
    logic                   bypass;
    logic                   ack;
    logic [31:0]            dat;
  } lmd_state_s;

endpackage
